//--- common/sar_cfg.svh
// frame timing and field constants for the serial converter readout
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH
`define SAR_RES_W        14
`define SAR_FRAME_BITS   5'h10
`define SAR_LSB_EDGE     5'h0F
`define SAR_PD_LO_EDGE   5'h02
`define SAR_PD_HI_EDGE   5'h0A
`define SAR_WAKE_EDGES   5'h10
`define SAR_CNT_RST      5'h00
`define SAR_SHIFT_RST    16'h0000
`define SAR_FLAG_RST     1'h0
`define SAR_PWR_RST      1'h1
`define SAR_PIN_IDLE     1'h1
`endif

//--- common/sar_pkg.sv
// types shared by the serial converter readout
package sar_pkg;
	typedef enum logic [1:0] {
		SAR_IDLE,
		SAR_SHIFT,
		SAR_DONE
	} sar_state_t;
	typedef logic [13:0] sar_sample_t;
endpackage

//--- hw/sar_sync.sv
// two flop synchroniser with edge detect on the settled copy
`timescale 1ns/10ps
`include "sar_cfg.svh"
module sar_sync (
	// clock and reset
	input  wire logic clock,
	input  wire logic rstn,
	// pin side
	input  wire logic pin_in,
	// synchronised side
	output logic      level_q,
	output logic      rise,
	output logic      fall
);
	logic meta_q;
	logic sync_q;

	// edges from the second flop against the level copy, saves one clock of latency
	assign rise = sync_q & ~level_q;
	assign fall = ~sync_q & level_q;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta_q  <= `SAR_PIN_IDLE;
			sync_q  <= `SAR_PIN_IDLE;
			level_q <= `SAR_PIN_IDLE;
		end else begin
			meta_q  <= pin_in;
			sync_q  <= meta_q;
			level_q <= sync_q;
		end
	end
endmodule

//--- hw/sar_readout.sv
// serial readout and conversion control of a 14-bit sampling converter
`timescale 1ns/10ps
`include "sar_cfg.svh"
module sar_readout
	import sar_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// serial link pins
	input  wire logic        cs_n,
	input  wire logic        sclk,
	output logic             serial_result_out,
	output logic             serial_result_oe,
	// converter core side
	input  wire sar_sample_t sample_in,
	output logic             hold_q,
	output logic             powered_q,
	output logic             conv_done_q
);
	// synchronised link pins
	logic cs_lvl;
	logic cs_rise;
	logic cs_fall;
	logic sc_rise;
	logic sc_fall;

	// select pin: two flops, a level copy, then edge detect
	sar_sync u_cs_sync (
		.clock   (clock),
		.rstn    (rstn),
		.pin_in  (cs_n),
		.level_q (cs_lvl),
		.rise    (cs_rise),
		.fall    (cs_fall)
	);

	// serial clock pin, idles high between frames
	sar_sync u_sc_sync (
		.clock   (clock),
		.rstn    (rstn),
		.pin_in  (sclk),
		.level_q (),
		.rise    (sc_rise),
		.fall    (sc_fall)
	);

	sar_state_t  state_q;
	sar_state_t  state_d;
	logic [4:0]  edge_q;
	logic [4:0]  edge_d;
	logic [15:0] shift_q;
	wire  [15:0] shift_d;
	logic        hold_d;
	logic        oe_d;
	logic        out_d;
	logic        pwr_d;
	logic        done_d;
	logic        waking_q;
	logic        waking_d;
	logic        load;
	logic        step;

	// decode of the synchronised pins and the falling edge count
	wire active       = (state_q != SAR_IDLE);
	wire start        = cs_fall;
	wire frame_edge   = active & sc_fall & ~cs_lvl;
	wire [4:0] edge_n = edge_q + 5'h01;
	wire last_edge    = frame_edge & (edge_n == `SAR_FRAME_BITS);
	wire lsb_passed   = (edge_q >= `SAR_LSB_EDGE);
	wire early_rise   = active & cs_rise & (edge_q < `SAR_FRAME_BITS);
	wire in_pd_window = (edge_q >= `SAR_PD_LO_EDGE) & (edge_q < `SAR_PD_HI_EDGE);
	wire past_ten     = (edge_q >= `SAR_PD_HI_EDGE);
	// two zeros then result msb first
	wire [15:0] frame = {2'h0, sample_in};

	// frame register, one slot per bit: load the whole frame or move up one place
	wire [15:0] shift_up = {shift_q[14:0], 1'h0};
	for (genvar b = 0; b < `SAR_FRAME_BITS; b++) begin : g_shift
		assign shift_d[b] = load ? frame[b] : (step ? shift_up[b] : shift_q[b]);
	end

	// sequencer: idle, shifting, then waiting for select to rise
	always_comb begin
		state_d  = state_q;
		edge_d   = edge_q;
		load     = 1'h0;
		step     = 1'h0;
		hold_d   = hold_q;
		oe_d     = serial_result_oe;
		out_d    = serial_result_out;
		pwr_d    = powered_q;
		done_d   = 1'h0;
		waking_d = waking_q;
		case (state_q)
			SAR_IDLE: begin
				// clock edges ignored while idle
				oe_d = 1'h0;
				if (start) begin
					state_d  = SAR_SHIFT;
					edge_d   = `SAR_CNT_RST;
					hold_d   = 1'h1;
					oe_d     = 1'h1;
					load     = 1'h1;
					out_d    = frame[15];
					waking_d = ~powered_q;
				end
			end
			SAR_SHIFT: begin
				if (early_rise) begin
					state_d = SAR_IDLE;
					oe_d    = 1'h0;
					hold_d  = 1'h0;
					if (in_pd_window & ~waking_q)
						pwr_d = 1'h0;
					else if (past_ten)
						pwr_d = 1'h1;
				end else if (last_edge) begin
					state_d = SAR_DONE;
					edge_d  = edge_n;
					oe_d    = 1'h0;
					done_d  = ~waking_q;
					pwr_d   = 1'h1;
				end else if (frame_edge) begin
					edge_d  = edge_n;
					step    = 1'h1;
					out_d   = shift_q[14];
				end else if (sc_rise & lsb_passed) begin
					hold_d = 1'h0;
				end
			end
			SAR_DONE: begin
				hold_d = 1'h0;
				if (cs_rise)
					state_d = SAR_IDLE;
			end
			default: begin
				state_d = SAR_IDLE;
			end
		endcase
	end

	// frame sequencing and falling edge count
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q <= SAR_IDLE;
			edge_q  <= `SAR_CNT_RST;
		end else begin
			state_q <= state_d;
			edge_q  <= edge_d;
		end
	end

	// frame bits waiting to go out
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			shift_q <= `SAR_SHIFT_RST;
		end else begin
			shift_q <= shift_d;
		end
	end

	// data line and its enable
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			serial_result_oe  <= `SAR_FLAG_RST;
			serial_result_out <= `SAR_FLAG_RST;
		end else begin
			serial_result_oe  <= oe_d;
			serial_result_out <= out_d;
		end
	end

	// track and hold control
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hold_q <= `SAR_FLAG_RST;
		end else begin
			hold_q <= hold_d;
		end
	end

	// power state and wake-up conversion marker
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			powered_q <= `SAR_PWR_RST;
			waking_q  <= `SAR_FLAG_RST;
		end else begin
			powered_q <= pwr_d;
			waking_q  <= waking_d;
		end
	end

	// one pulse per valid conversion
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			conv_done_q <= `SAR_FLAG_RST;
		end else begin
			conv_done_q <= done_d;
		end
	end
endmodule

//--- verif/sar_readout_checker.sv
// pin checks of the readout
`timescale 1ns/10ps
module sar_readout_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_result_out,
	input wire logic serial_result_oe,
	input wire logic hold_q,
	input wire logic powered_q,
	input wire logic conv_done_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	AST_IDLE_OFF: assert property (cs_n [*8] |-> !serial_result_oe)
		else $error("idle drive");
	AST_CS_FALL: assert property ($fell(cs_n) |->
		##[3:6] (serial_result_oe && hold_q && !serial_result_out))
		else $error("no start");
	AST_ABORT: assert property ($rose(cs_n) |-> ##[1:6] !serial_result_oe)
		else $error("no abort");
	AST_DONE_OFF: assert property (conv_done_q |-> ##[0:1] !serial_result_oe)
		else $error("no release");
	AST_DONE_ONE: assert property (conv_done_q |=> !conv_done_q)
		else $error("long done");
	AST_SHIFT: assert property (serial_result_oe && $past(serial_result_oe)
		&& $changed(serial_result_out) |-> !$past(sclk, 3))
		else $error("bad shift");
	AST_TRACK: assert property ($fell(hold_q) |-> $past(sclk, 3))
		else $error("bad track");
	AST_PWR: assert property ($changed(powered_q) |-> (cs_n || !serial_result_oe))
		else $error("bad power");
	cover property (conv_done_q);
	cover property ($fell(powered_q));
	cover property ($rose(powered_q));
endmodule

//--- verif/sar_host.sv
// host serial port model
`timescale 1ns/10ps
module sar_host (
	input wire logic clock,
	output logic     cs_n,
	output logic     sclk,
	input wire logic serial_result_out,
	input wire logic serial_result_oe
);
	logic        line;
	// word as a host capturing on rising edges sees it
	logic [15:0] rise_w;
	// released line shows no stale bit
	assign line = serial_result_oe ? serial_result_out : ~serial_result_out;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
	end
	task automatic frame(input int n, output logic [15:0] w);
		w = 16'h0000;
		rise_w = 16'h0000;
		@(posedge clock) cs_n <= 1'b0;
		repeat (8) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			w = {w[14:0], line};
			if (i == 0)
				rise_w = w;
			sclk <= 1'b0;
			repeat (4) @(posedge clock);
			if (i < 15)
				rise_w = {rise_w[14:0], line};
			sclk <= 1'b1;
			repeat (4) @(posedge clock);
		end
		cs_n <= 1'b1;
		repeat (12) @(posedge clock);
	endtask
endmodule

//--- verif/sar_readout_tb.sv
// bench for the readout
`timescale 1ns/10ps
module sar_readout_tb;
	logic                 clock, rstn, cs_n, sclk, serial_result_out, serial_result_oe;
	logic                 hold_q, powered_q, conv_done_q;
	sar_pkg::sar_sample_t sample_in;
	logic [15:0]          w;
	int                   error_cnt, compares, dones;
	logic [29:0]          rows [3] = '{{14'h3FFF, 16'h3FFF}, {14'h2AAA, 16'h2AAA},
		{14'h1555, 16'h1555}};
	sar_readout dut_u (.clock, .rstn, .cs_n, .sclk, .serial_result_out,
		.serial_result_oe, .sample_in, .hold_q, .powered_q, .conv_done_q);
	sar_host host_u (.clock, .cs_n, .sclk, .serial_result_out, .serial_result_oe);
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) if (conv_done_q === 1'b1) dones++;
	task chk(input logic [15:0] s, e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task end_of_test;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge clock);
		error_cnt++;
		end_of_test;
	end
	initial begin
		rstn = 1'b0;
		sample_in = 14'h0000;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			sample_in <= rows[i][29:16];
			host_u.frame(16, w);
			chk(w, rows[i][15:0]);
			chk(host_u.rise_w, rows[i][15:0]);
			chk(16'({hold_q, serial_result_oe}), 16'h0000);
		end
		host_u.frame(8, w);
		chk(16'(powered_q), 16'h0000);
		host_u.frame(1, w);
		chk(16'(powered_q), 16'h0000);
		host_u.frame(12, w);
		chk(16'(powered_q), 16'h0001);
		sample_in <= 14'h2001;
		host_u.frame(16, w);
		chk(w, 16'h2001);
		host_u.frame(1, w);
		host_u.frame(12, w);
		chk(16'(powered_q), 16'h0001);
		chk(16'(dones), 16'h0004);
		host_u.frame(8, w);
		rstn <= 1'b0;
		@(posedge clock);
		chk(16'({powered_q, serial_result_oe}), 16'h0002);
		rstn <= 1'b1;
		sample_in <= 14'h0ABC;
		host_u.frame(16, w);
		chk(w, 16'h0ABC);
		chk(host_u.rise_w, 16'h0ABC);
		end_of_test;
	end
endmodule
bind sar_readout sar_readout_checker chk_u (.clock, .rstn, .cs_n, .sclk, .serial_result_out,
	.serial_result_oe, .hold_q, .powered_q, .conv_done_q);
